// file: include/uart_fc_pkg.sv
// Constants, state codes and trigger tables for the UART flow-control channel.
// Assumes one 125 MHz system clock that also serves as the baud reference.
// How it works
// - Auto CTS/RTS only when enable bits set
// - CTS high: finish stop bit, pause, flag
// - Trigger raises interrupt; RTS off at fill of 4, 8, 12 or 14 per trigger select
// - RTS back on at fill of 1, 4, 8 or 10 per trigger select
// - Receiver keeps storing until buffer full
// - Stop-character match halts transmit after current character
// - Stop match sets flag, drives interrupt if enabled
// - Resume-character match restarts transmit, clears flag
// - Reset zeroes all four flow-control characters
// - Double mode matches two consecutive characters
// - Consumed flow characters never enter receive buffer
// - Send stop characters when fill passes trigger
// - Send resume characters when fill drops below
// - Special mode: second stop char stored, flagged
// - Compare only programmed word length bits
// - Enable bits gate interrupts; idle transmitter interrupts
// - Report single highest source; CTS/RTS lowest
// - Time-out outranks data-ready; both share one enable bit
// - Time-out after four characters; restart on stop/read
// - Select pin high forces interrupt output driven
// - Sixteen-bit divisor makes the 16x tick
// - Enhanced registers writable only with key value
// - Divisor bytes writable only with latch bit set
package uart_fc_pkg;

  // ---------------------------------------------------------------
  // Register access keys and addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ENH_KEY    = 8'hbf;  // Line format value opening enhanced set
  localparam int         DIVL_BIT   = 7;      // Line format bit opening divisor bytes
  localparam logic [2:0] ADR_DIV_LO = 3'h0;
  localparam logic [2:0] ADR_DIV_HI = 3'h1;
  localparam logic [2:0] ADR_EFR    = 3'h2;
  localparam logic [2:0] ADR_RES1   = 3'h4;
  localparam logic [2:0] ADR_RES2   = 3'h5;
  localparam logic [2:0] ADR_STOP1  = 3'h6;
  localparam logic [2:0] ADR_STOP2  = 3'h7;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int EF_AUTO_CTS = 7;
  localparam int EF_AUTO_RTS = 6;
  localparam int EF_SPECIAL  = 5;
  localparam int IE_RX       = 0;
  localparam int IE_THR      = 1;
  localparam int IE_STOP     = 5;
  localparam int IE_RTS      = 6;
  localparam int IE_CTS      = 7;
  localparam logic [7:0]  CHAR_RESET = 8'h00;
  localparam logic [7:0]  DIV_LO_RST = 8'h01;  // Plain default divisor of one
  localparam logic [1:0]  CMP_NONE   = 2'h0;   // Flow-char mode codes
  localparam logic [1:0]  CMP_ONE2   = 2'h1;
  localparam logic [1:0]  CMP_ONE1   = 2'h2;
  localparam logic [1:0]  CMP_DOUBLE = 2'h3;

  // ---------------------------------------------------------------
  // Interrupt source codes, highest priority first
  // ---------------------------------------------------------------
  localparam logic [5:0] ISR_NONE  = 6'h01;
  localparam logic [5:0] ISR_TOUT  = 6'h0c;
  localparam logic [5:0] ISR_RXDAT = 6'h04;
  localparam logic [5:0] ISR_THR   = 6'h02;
  localparam logic [5:0] ISR_CHAR  = 6'h10;
  localparam logic [5:0] ISR_FLOW  = 6'h20;

  // ---------------------------------------------------------------
  // Bit timing
  // ---------------------------------------------------------------
  localparam logic [3:0] PH_MID   = 4'h7;   // Eighth tick of sixteen
  localparam logic [3:0] PH_LAST  = 4'hf;
  localparam int OVERSAMPLE    = 16;
  localparam int TOUT_CHARS    = 4;
  localparam int BITS_PER_CHAR = 10;
  localparam int TOUT_TICKS    = TOUT_CHARS * BITS_PER_CHAR * OVERSAMPLE;

  // Receiver state machine
  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } rx_state_t;

  // Trigger, stop and resume fill levels per trigger select
  function automatic logic [4:0] trig_level(input logic [1:0] sel);
    case (sel)
      2'h0:    trig_level = 5'd1;
      2'h1:    trig_level = 5'd4;
      2'h2:    trig_level = 5'd8;
      default: trig_level = 5'd14;
    endcase
  endfunction : trig_level

  function automatic logic [4:0] stop_level(input logic [1:0] sel);
    case (sel)
      2'h0:    stop_level = 5'd4;
      2'h1:    stop_level = 5'd8;
      2'h2:    stop_level = 5'd12;
      default: stop_level = 5'd14;
    endcase
  endfunction : stop_level

  function automatic logic [4:0] resume_level(input logic [1:0] sel);
    case (sel)
      2'h0:    resume_level = 5'd1;
      2'h1:    resume_level = 5'd4;
      2'h2:    resume_level = 5'd8;
      default: resume_level = 5'd10;
    endcase
  endfunction : resume_level

endpackage : uart_fc_pkg

// file: src/uart_flow_ctrl_baud_gen.sv
// One UART channel: baud tick, transmitter, receiver, receive buffer,
// hardware and character flow control, time-out and interrupt source.
// Assumes the serial pins and strap arrive asynchronously to SYS_CLK.
module uart_flow_ctrl_baud_gen #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input  wire logic       SYS_CLK,
  input  wire logic       RST_N,
  // Serial and modem pins
  input  wire logic       RX,
  output logic            TX,
  input  wire logic       CTS_N,
  output logic            RTS_N,
  // Interrupt pin
  input  wire logic       INTERRUPT_OUTPUT_SELECT,
  output logic            INT_O,
  output logic            INT_OE,
  // Enhanced and divisor register writes
  input  wire logic       WR_STB,
  input  wire logic [2:0] WR_ADDR,
  input  wire logic [7:0] WR_DATA,
  // Control bits
  input  wire logic [7:0] LINE_FORMAT_CTRL,
  input  wire logic [7:0] INTERRUPT_ENABLE_MASK,
  input  wire logic [1:0] TRIG_SEL,
  input  wire logic       MODEM_RTS,
  input  wire logic       MODEM_INT_EN,
  // Transmit data
  input  wire logic       TX_VALID,
  input  wire logic [7:0] TX_DATA,
  output logic            TX_READY,
  // Receive data
  input  wire logic       RX_RD,
  output logic [7:0]      RX_DATA,
  output logic [5:0]      RX_LEVEL,
  // Status
  input  wire logic       ISR_RD,
  output logic [5:0]      ISR_CODE,
  output logic            TX_HALTED
);

  localparam int AW = $clog2(FIFO_DEPTH);

  // Depth must be 16, the smallest power of two holding the top trigger level
  if (FIFO_DEPTH < 16 || FIFO_DEPTH > 16) begin : g_depth_chk
    $error("FIFO_DEPTH must be 16");
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]                  div_lo, div_hi;        // Divisor bytes
    logic [7:0]                  enhanced_feature_ctrl;                   // Enhanced features
    logic [7:0]                  res1, res2;            // Resume characters
    logic [7:0]                  stop1, stop2;          // Stop characters
    logic [15:0]                 bcnt;                  // Baud divider
    logic                        tick;                  // 16x tick
    logic                        rx_m, rx_q;            // Receive synchroniser
    logic                        cts_m, cts_q, cts_d;   // CTS synchroniser, delay
    logic                        sel_m, sel_q;          // Strap synchroniser
    logic [9:0]                  tx_sh;                 // Transmit shifter
    logic [3:0]                  tx_ph, tx_bit;
    logic                        tx_busy;
    uart_fc_pkg::rx_state_t      rx_st;
    logic [3:0]                  rx_ph;
    logic [2:0]                  rx_bit;
    logic [7:0]                  rx_sh;
    logic [FIFO_DEPTH-1:0][7:0]  mem;                   // Receive buffer
    logic [AW-1:0]               wp, rp;
    logic [AW:0]                 cnt;
    logic [7:0]                  rx_data;
    logic                        stop_half, res_half;   // First of pair seen
    logic                        tx_stop;               // Halted by stop char
    logic                        rts_n;
    logic                        f_char, f_cts, f_rts;  // Sticky sources
    logic [1:0]                  ctl_pend;              // Flow chars to send
    logic                        ctl_res;               // Sending resume chars
    logic                        stop_sent;
    logic [9:0]                  tout;
    logic                        tout_hit;
    logic [5:0]                  interrupt_source_status;
    logic                        irq;
  } st_t;

  st_t s, n;

  // Word length helpers
  logic [3:0]  dbits;      // Data bits 5..8
  logic [7:0]  mask;       // Compare mask
  logic [15:0] div_m1;
  logic [7:0]  rxc, ctl_ch;
  logic [1:0]  rmode, tmode;
  logic        halt_hw, send_ctl, rx_done, consume, pop, wr, dbl;
  logic        a_stop, a_res;
  logic [4:0]  trig, hi, lo;
  logic [5:0]  code;

  // Masked character compare
  function automatic logic eq(input logic [7:0] a, input logic [7:0] b,
                              input logic [7:0] m);
    eq = ((a ^ b) & m) == 8'h00;
  endfunction : eq

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    n       = s;
    n.tick  = 1'b0;
    rx_done = 1'b0;
    consume = 1'b0;
    a_stop  = 1'b0;
    a_res   = 1'b0;
    wr      = 1'b0;
    dbits   = 4'h5 + {2'b00, LINE_FORMAT_CTRL[1:0]};
    mask    = 8'hff >> (2'h3 - LINE_FORMAT_CTRL[1:0]);
    rmode   = s.enhanced_feature_ctrl[1:0];
    tmode   = s.enhanced_feature_ctrl[3:2];
    dbl     = rmode == uart_fc_pkg::CMP_DOUBLE;
    trig    = uart_fc_pkg::trig_level(TRIG_SEL);
    hi      = uart_fc_pkg::stop_level(TRIG_SEL);
    lo      = uart_fc_pkg::resume_level(TRIG_SEL);
    pop     = RX_RD && s.cnt != '0;
    rxc     = 8'(s.rx_sh >> (4'h8 - dbits));
    // Synchronisers
    n.rx_m  = RX;
    n.rx_q  = s.rx_m;
    n.cts_m = CTS_N;
    n.cts_q = s.cts_m;
    n.cts_d = s.cts_q;
    n.sel_m = INTERRUPT_OUTPUT_SELECT;
    n.sel_q = s.sel_m;
    // Status read clears a reported flow source, or the char source in special mode, first, so sets below win
    if (ISR_RD && s.interrupt_source_status == uart_fc_pkg::ISR_FLOW) begin
      n.f_cts = 1'b0;
      n.f_rts = 1'b0;
    end
    if (ISR_RD && s.interrupt_source_status == uart_fc_pkg::ISR_CHAR && s.enhanced_feature_ctrl[uart_fc_pkg::EF_SPECIAL]) begin
      n.f_char = 1'b0;
    end
    // Register writes, enhanced key taking precedence
    if (WR_STB && LINE_FORMAT_CTRL == uart_fc_pkg::ENH_KEY) begin
      case (WR_ADDR)
        uart_fc_pkg::ADR_EFR:   n.enhanced_feature_ctrl   = WR_DATA;
        uart_fc_pkg::ADR_RES1:  n.res1  = WR_DATA;
        uart_fc_pkg::ADR_RES2:  n.res2  = WR_DATA;
        uart_fc_pkg::ADR_STOP1: n.stop1 = WR_DATA;
        uart_fc_pkg::ADR_STOP2: n.stop2 = WR_DATA;
        default: ;
      endcase
    end else if (WR_STB && LINE_FORMAT_CTRL[uart_fc_pkg::DIVL_BIT]) begin
      if (WR_ADDR == uart_fc_pkg::ADR_DIV_LO) n.div_lo = WR_DATA;
      if (WR_ADDR == uart_fc_pkg::ADR_DIV_HI) n.div_hi = WR_DATA;
    end
    // Baud divider, zero treated as one
    div_m1 = ({s.div_hi, s.div_lo} == 16'h0000) ? 16'h0000
           : 16'({s.div_hi, s.div_lo} - 16'h0001);
    if (s.bcnt >= div_m1) begin
      n.bcnt = 16'h0000;
      n.tick = 1'b1;
    end else begin
      n.bcnt = 16'(s.bcnt + 16'h0001);
    end
    // Transmit: halts only gate the start of the next character
    halt_hw  = s.enhanced_feature_ctrl[uart_fc_pkg::EF_AUTO_CTS] & s.cts_q;
    send_ctl = s.ctl_pend != 2'h0;
    ctl_ch   = (s.ctl_pend == 2'h2 || tmode == uart_fc_pkg::CMP_ONE1)
             ? (s.ctl_res ? s.res1 : s.stop1)
             : (s.ctl_res ? s.res2 : s.stop2);
    if (!s.tx_busy && !halt_hw && (send_ctl || (TX_VALID && !s.tx_stop))) begin
      n.tx_sh   = {1'b1, (send_ctl ? ctl_ch : TX_DATA) | ~mask, 1'b0};
      n.tx_busy = 1'b1;
      n.tx_ph   = 4'h0;
      n.tx_bit  = 4'h0;
      if (send_ctl) n.ctl_pend = 2'(s.ctl_pend - 2'h1);
    end else if (s.tx_busy && s.tick) begin
      if (s.tx_ph == uart_fc_pkg::PH_LAST) begin
        n.tx_ph = 4'h0;
        n.tx_sh = {1'b1, s.tx_sh[9:1]};
        if (s.tx_bit == 4'(dbits + 4'h1)) n.tx_busy = 1'b0;
        else n.tx_bit = 4'(s.tx_bit + 4'h1);
      end else begin
        n.tx_ph = 4'(s.tx_ph + 4'h1);
      end
    end
    // Receive sampler
    case (s.rx_st)
      uart_fc_pkg::RX_IDLE: begin
        if (s.tick && !s.rx_q) begin
          n.rx_st = uart_fc_pkg::RX_START;
          n.rx_ph = 4'h0;
        end
      end
      uart_fc_pkg::RX_START: begin
        if (s.tick && s.rx_ph == uart_fc_pkg::PH_MID) begin
          // False start returns to idle
          n.rx_st  = s.rx_q ? uart_fc_pkg::RX_IDLE : uart_fc_pkg::RX_DATA;
          n.rx_ph  = 4'h0;
          n.rx_bit = 3'h0;
        end else if (s.tick) begin
          n.rx_ph = 4'(s.rx_ph + 4'h1);
        end
      end
      uart_fc_pkg::RX_DATA: begin
        if (s.tick && s.rx_ph == uart_fc_pkg::PH_LAST) begin
          n.rx_ph = 4'h0;
          n.rx_sh = {s.rx_q, s.rx_sh[7:1]};
          if (s.rx_bit == 3'(dbits - 4'h1)) n.rx_st = uart_fc_pkg::RX_STOP;
          else n.rx_bit = 3'(s.rx_bit + 3'h1);
        end else if (s.tick) begin
          n.rx_ph = 4'(s.rx_ph + 4'h1);
        end
      end
      uart_fc_pkg::RX_STOP: begin
        if (s.tick && s.rx_ph == uart_fc_pkg::PH_LAST) begin
          n.rx_st = uart_fc_pkg::RX_IDLE;
          rx_done = 1'b1;
        end else if (s.tick) begin
          n.rx_ph = 4'(s.rx_ph + 4'h1);
        end
      end
      default: n.rx_st = uart_fc_pkg::RX_IDLE;
    endcase
    // Time-out counts ticks while data waits
    if (s.cnt == '0) begin
      n.tout     = 10'h000;
      n.tout_hit = 1'b0;
    end else if (s.tick && !s.tout_hit) begin
      if (s.tout == 10'(uart_fc_pkg::TOUT_TICKS - 1)) n.tout_hit = 1'b1;
      else n.tout = 10'(s.tout + 10'h001);
    end
    if (rx_done || pop) begin
      n.tout     = 10'h000;
      n.tout_hit = 1'b0;
    end
    // Character matching at the stop-bit centre
    if (rx_done && s.enhanced_feature_ctrl[uart_fc_pkg::EF_SPECIAL]) begin
      if (eq(rxc, s.stop2, mask)) n.f_char = 1'b1;
    end else if (rx_done && rmode != uart_fc_pkg::CMP_NONE) begin
      a_stop = dbl ? (s.stop_half && eq(rxc, s.stop2, mask))
             : eq(rxc, rmode == uart_fc_pkg::CMP_ONE1 ? s.stop1 : s.stop2, mask);
      a_res  = dbl ? (s.res_half && eq(rxc, s.res2, mask))
             : eq(rxc, rmode == uart_fc_pkg::CMP_ONE1 ? s.res1 : s.res2, mask);
      n.stop_half = dbl && eq(rxc, s.stop1, mask);
      n.res_half  = dbl && eq(rxc, s.res1, mask);
      consume = a_stop || a_res || n.stop_half || n.res_half;
      if (a_stop) begin
        n.tx_stop = 1'b1;
        if (INTERRUPT_ENABLE_MASK[uart_fc_pkg::IE_STOP]) n.f_char = 1'b1;
      end else if (a_res && s.tx_stop) begin
        n.tx_stop = 1'b0;
        n.f_char  = 1'b0;
      end
    end
    // Buffer write and read; storing continues while RTS is off
    wr = rx_done && !consume && s.cnt != (AW+1)'(FIFO_DEPTH);
    if (wr) begin
      n.mem[s.wp] = rxc;
      n.wp        = AW'(s.wp + 1'b1);
    end
    if (pop) begin
      n.rx_data = s.mem[s.rp];
      n.rp      = AW'(s.rp + 1'b1);
    end
    n.cnt = (AW+1)'(s.cnt + {{AW{1'b0}}, wr} - {{AW{1'b0}}, pop});
    // Automatic RTS with hysteresis
    if (s.enhanced_feature_ctrl[uart_fc_pkg::EF_AUTO_RTS]) begin
      if (s.cnt >= (AW+1)'(hi)) n.rts_n = 1'b1;
      else if (s.cnt <= (AW+1)'(lo)) n.rts_n = 1'b0;
    end else begin
      n.rts_n = ~MODEM_RTS;
    end
    if (!s.rts_n && n.rts_n && INTERRUPT_ENABLE_MASK[uart_fc_pkg::IE_RTS]) begin
      n.f_rts = 1'b1;
    end
    if (s.cts_q && !s.cts_d && s.enhanced_feature_ctrl[uart_fc_pkg::EF_AUTO_CTS]
        && INTERRUPT_ENABLE_MASK[uart_fc_pkg::IE_CTS]) begin
      n.f_cts = 1'b1;
    end
    // Automatic stop and resume character sending
    if (tmode != uart_fc_pkg::CMP_NONE && !send_ctl) begin
      if (!s.stop_sent && s.cnt > (AW+1)'(trig)) begin
        n.ctl_pend  = (tmode == uart_fc_pkg::CMP_DOUBLE) ? 2'h2 : 2'h1;
        n.ctl_res   = 1'b0;
        n.stop_sent = 1'b1;
      end else if (s.stop_sent && s.cnt < (AW+1)'(trig)) begin
        n.ctl_pend  = (tmode == uart_fc_pkg::CMP_DOUBLE) ? 2'h2 : 2'h1;
        n.ctl_res   = 1'b1;
        n.stop_sent = 1'b0;
      end
    end
    // Single highest-priority source
    if (INTERRUPT_ENABLE_MASK[uart_fc_pkg::IE_RX] && s.tout_hit) begin
      code = uart_fc_pkg::ISR_TOUT;
    end else if (INTERRUPT_ENABLE_MASK[uart_fc_pkg::IE_RX] && s.cnt >= (AW+1)'(trig)) begin
      code = uart_fc_pkg::ISR_RXDAT;
    end else if (INTERRUPT_ENABLE_MASK[uart_fc_pkg::IE_THR] && !s.tx_busy) begin
      code = uart_fc_pkg::ISR_THR;
    end else if (s.f_char && INTERRUPT_ENABLE_MASK[uart_fc_pkg::IE_RX]) begin
      code = uart_fc_pkg::ISR_CHAR;
    end else if (s.f_cts || s.f_rts) begin
      code = uart_fc_pkg::ISR_FLOW;
    end else begin
      code = uart_fc_pkg::ISR_NONE;
    end
    n.interrupt_source_status = code;
    n.irq = code != uart_fc_pkg::ISR_NONE;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      s        <= '0;
      s.div_lo <= uart_fc_pkg::DIV_LO_RST;
      s.res1   <= uart_fc_pkg::CHAR_RESET;
      s.res2   <= uart_fc_pkg::CHAR_RESET;
      s.stop1  <= uart_fc_pkg::CHAR_RESET;
      s.stop2  <= uart_fc_pkg::CHAR_RESET;
      s.tx_sh  <= '1;
      s.rx_m   <= 1'b1;
      s.rx_q   <= 1'b1;
      s.rx_st  <= uart_fc_pkg::RX_IDLE;
      s.rts_n  <= 1'b1;
      s.interrupt_source_status    <= uart_fc_pkg::ISR_NONE;
    end else begin
      s <= n;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign TX        = s.tx_sh[0];
  assign RTS_N     = s.rts_n;
  assign INT_O     = s.irq;
  assign INT_OE    = s.sel_q | MODEM_INT_EN;
  assign TX_READY  = !s.tx_busy && !halt_hw && !send_ctl && !s.tx_stop;
  assign RX_DATA   = s.rx_data;
  assign RX_LEVEL  = 6'(s.cnt);
  assign ISR_CODE  = s.interrupt_source_status;
  assign TX_HALTED = s.tx_stop | halt_hw;

endmodule : uart_flow_ctrl_baud_gen

// file: testbench/uart_fc_props.sv
// Port checker for the UART channel, bound to every instance.
// Assumes flow enables change only through enhanced-register writes.
module uart_fc_props (
  // Clock and reset
  input wire logic       SYS_CLK,
  input wire logic       RST_N,
  // Pins
  input wire logic       TX,
  input wire logic       CTS_N,
  input wire logic       RTS_N,
  input wire logic       INTERRUPT_OUTPUT_SELECT,
  input wire logic       INT_O,
  input wire logic       INT_OE,
  // Controls and status
  input wire logic       MODEM_RTS,
  input wire logic       MODEM_INT_EN,
  input wire logic       WR_STB,
  input wire logic [2:0] WR_ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic [7:0] LINE_FORMAT_CTRL,
  input wire logic       TX_VALID,
  input wire logic       TX_READY,
  input wire logic [5:0] RX_LEVEL,
  input wire logic [5:0] ISR_CODE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  logic [7:0] enhanced_feature_ctrl;  // Shadow of the enhanced enables
  // Track enhanced writes made under the key value
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      enhanced_feature_ctrl <= 8'h00;
    end else if (WR_STB && LINE_FORMAT_CTRL == 8'hbf && WR_ADDR == 3'h2) begin
      enhanced_feature_ctrl <= WR_DATA;
    end
  end
  int_oe_a: assert property (MODEM_INT_EN |-> INT_OE) else $error("oe low");
  strap_oe_a: assert property (INTERRUPT_OUTPUT_SELECT [*3] |-> INT_OE) else $error("strap oe");
  rts_manual_a: assert property ((!enhanced_feature_ctrl[6] && $stable(MODEM_RTS)) [*3]
    |-> RTS_N == !MODEM_RTS) else $error("manual rts");
  rts_full_a: assert property ((enhanced_feature_ctrl[6] && RX_LEVEL == 6'd16) [*2] |-> RTS_N)
    else $error("rts not off");
  rts_empty_a: assert property ((enhanced_feature_ctrl[6] && RX_LEVEL == 6'd0) [*3] |-> !RTS_N)
    else $error("rts not on");
  cts_halt_a: assert property ((enhanced_feature_ctrl[7] && CTS_N) [*4] |-> !TX_READY)
    else $error("cts ignored");
  level_max_a: assert property (RX_LEVEL <= 6'd16) else $error("level over");
  tx_idle_a: assert property (TX_READY |-> TX) else $error("idle low");
  start_bit_a: assert property (TX_VALID && TX_READY |=> !TX && !TX_READY)
    else $error("no start");
  int_code_a: assert property (INT_O |-> ISR_CODE != 6'h01)
    else $error("int no source");
  tout_empty_a: assert property ((RX_LEVEL == 6'd0) [*3] |-> ISR_CODE != 6'h0c)
    else $error("timeout empty");
  cover property (enhanced_feature_ctrl[6] && RTS_N && RX_LEVEL == 6'd16);
  cover property (ISR_CODE == 6'h0c);
  cover property (enhanced_feature_ctrl[7] && CTS_N && !TX_READY);
endmodule : uart_fc_props

bind uart_flow_ctrl_baud_gen uart_fc_props u_props (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
  .TX(TX), .CTS_N(CTS_N), .RTS_N(RTS_N), .INTERRUPT_OUTPUT_SELECT(INTERRUPT_OUTPUT_SELECT), .INT_O(INT_O),
  .INT_OE(INT_OE), .MODEM_RTS(MODEM_RTS), .MODEM_INT_EN(MODEM_INT_EN),
  .WR_STB(WR_STB), .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA),
  .LINE_FORMAT_CTRL(LINE_FORMAT_CTRL), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
  .RX_LEVEL(RX_LEVEL), .ISR_CODE(ISR_CODE));

// file: testbench/uart_flow_ctrl_baud_gen_tb.sv
// Self-checking bench for the UART channel and its remote peer.
// Assumes divisor 2, so one bit lasts 32 system clocks.
module uart_flow_ctrl_baud_gen_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0, rst_n = 1'b0, cts_n = 1'b0, interrupt_output_select = 1'b0, mie = 1'b0;
  logic       wr = 1'b0, txv = 1'b0, rd = 1'b0, isr_rd = 1'b0, mrts = 1'b0;
  logic [2:0] wa = 3'h0;
  logic [7:0] wd = 8'h00, line_format_ctrl = 8'h03, ie = 8'h00, txd = 8'h00, rxd;
  logic [1:0] trig = 2'h3;
  logic       rx, tx, rts_n, int_o, int_oe, txr, halted;
  logic [5:0] lvl, interrupt_source_status;
  int         err_count = 0, tests_run = 0;
  always #4 clk = ~clk;
  uart_flow_ctrl_baud_gen dut (.SYS_CLK(clk), .RST_N(rst_n), .RX(rx), .TX(tx),
    .CTS_N(cts_n), .RTS_N(rts_n), .INTERRUPT_OUTPUT_SELECT(interrupt_output_select), .INT_O(int_o), .INT_OE(int_oe),
    .WR_STB(wr), .WR_ADDR(wa), .WR_DATA(wd), .LINE_FORMAT_CTRL(line_format_ctrl),
    .INTERRUPT_ENABLE_MASK(ie), .TRIG_SEL(trig), .MODEM_RTS(mrts), .MODEM_INT_EN(mie),
    .TX_VALID(txv), .TX_DATA(txd), .TX_READY(txr), .RX_RD(rd), .RX_DATA(rxd),
    .RX_LEVEL(lvl), .ISR_RD(isr_rd), .ISR_CODE(interrupt_source_status), .TX_HALTED(halted));
  uart_peer #(.DIV(2)) peer (.clk(clk), .rxd(rx), .txd(tx));
  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  // Strobed register write under a given line format
  task automatic wreg(input logic [7:0] l, input logic [2:0] a, input logic [7:0] d);
    line_format_ctrl = l;
    wa = a;
    wd = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    line_format_ctrl = 8'h03;
    cyc(1);
  endtask : wreg
  // Hold a byte until taken, bounded
  task automatic send_tx(input logic [7:0] d);
    int n;
    n = 0;
    txd = d;
    txv = 1'b1;
    while (!txr && n < 2000) begin
      cyc(1);
      n++;
    end
    cyc(1);
    txv = 1'b0;
    if (n >= 2000) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    end
  endtask : send_tx
  task automatic pop(input logic [7:0] exp);
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    cyc(1);
    chk(rxd, exp);
  endtask : pop
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  // Watchdog
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    wrap_up();
  end
  // Main sequence
  initial begin
    cyc(10);
    rst_n = 1'b1;
    cyc(2);
    chk(8'(rts_n), 8'h01);
    chk(8'(interrupt_source_status), 8'h01);
    ie = 8'h02;
    cyc(3);
    chk(8'(interrupt_source_status), 8'h02);
    chk(8'(int_o), 8'h01);
    chk(8'(int_oe), 8'h00);
    mie = 1'b1;
    cyc(1);
    chk(8'(int_oe), 8'h01);
    mie = 1'b0;
    interrupt_output_select = 1'b1;
    cyc(4);
    chk(8'(int_oe), 8'h01);
    wreg(8'h83, 3'h0, 8'h02);
    wreg(8'h83, 3'h1, 8'h00);
    wreg(8'h03, 3'h0, 8'h07);
    wreg(8'h83, 3'h2, 8'h40);
    cyc(3);
    chk(8'(rts_n), 8'h01);
    send_tx(8'ha5);
    cyc(400);
    chk(peer.got.pop_front(), 8'ha5);
    wreg(8'hbf, 3'h2, 8'h02);
    wreg(8'hbf, 3'h4, 8'h11);
    ie = 8'h23;
    peer.send(8'h00);
    cyc(4);
    chk(8'(halted), 8'h01);
    chk(8'(lvl), 8'h00);
    chk(8'(interrupt_source_status), 8'h02);
    ie = 8'h21;
    cyc(3);
    chk(8'(interrupt_source_status), 8'h10);
    peer.send(8'h11);
    cyc(4);
    chk(8'(halted), 8'h00);
    chk(8'(interrupt_source_status), 8'h01);
    wreg(8'hbf, 3'h2, 8'h00);
    ie = 8'h01;
    peer.glitch();
    chk(8'(lvl), 8'h00);
    peer.send(8'h3c);
    chk(8'(lvl), 8'h01);
    cyc(1100);
    chk(8'(interrupt_source_status), 8'h01);
    cyc(300);
    chk(8'(interrupt_source_status), 8'h0c);
    pop(8'h3c);
    cyc(3);
    chk(8'(interrupt_source_status), 8'h01);
    wreg(8'hbf, 3'h2, 8'h40);
    trig = 2'h1;
    for (int i = 1; i <= 17; i++) begin
      peer.send(8'(i));
      cyc(3);
      chk(8'(rts_n), 8'(i >= 8));
      if (i == 4) chk(8'(interrupt_source_status), 8'h04);
    end
    chk(8'(lvl), 8'h10);
    for (int j = 1; j <= 16; j++) begin
      pop(8'(j));
      cyc(2);
      chk(8'(rts_n), 8'(16 - j > 4));
    end
    wreg(8'hbf, 3'h2, 8'h00);
    cts_n = 1'b1;
    send_tx(8'h3a);
    cyc(400);
    chk(peer.got.pop_front(), 8'h3a);
    cts_n = 1'b0;
    wreg(8'hbf, 3'h2, 8'h80);
    ie = 8'h80;
    cyc(4);
    cts_n = 1'b1;
    cyc(4);
    chk(8'(interrupt_source_status), 8'h20);
    fork
      send_tx(8'hc3);
      begin
        cyc(40);
        chk(8'(halted), 8'h01);
        chk(8'(tx), 8'h01);
        cts_n = 1'b0;
      end
    join
    cyc(400);
    chk(peer.got.pop_front(), 8'hc3);
    isr_rd = 1'b1;
    cyc(1);
    isr_rd = 1'b0;
    cyc(2);
    chk(8'(interrupt_source_status), 8'h01);
    wreg(8'hbf, 3'h7, 8'h5a);
    wreg(8'hbf, 3'h2, 8'h20);
    ie = 8'h01;
    peer.send(8'h5a);
    cyc(4);
    chk(8'(lvl), 8'h01);
    chk(8'(interrupt_source_status), 8'h10);
    isr_rd = 1'b1;
    cyc(1);
    isr_rd = 1'b0;
    cyc(2);
    chk(8'(interrupt_source_status), 8'h01);
    pop(8'h5a);
    wreg(8'hbf, 3'h6, 8'h13);
    wreg(8'hbf, 3'h2, 8'h08);
    for (int k = 0; k < 5; k++) peer.send(8'h41);
    cyc(400);
    chk(peer.got.pop_front(), 8'h13);
    repeat (5) pop(8'h41);
    cyc(400);
    chk(peer.got.pop_front(), 8'h11);
    wrap_up();
  end
endmodule : uart_flow_ctrl_baud_gen_tb

// file: testbench/uart_peer.sv
// Remote serial peer: drives the receive line, decodes the transmit line.
// Assumes 8 data bits, one stop bit, bit time of 16 x DIV clocks.
module uart_peer #(
  parameter int DIV = 2  // Divisor set in the channel
) (
  input  wire logic clk,  // System clock
  output logic      rxd,  // Line into the channel
  input  wire logic txd   // Line out of the channel
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT = 16 * DIV;  // Clocks per bit
  logic [7:0] got [$];            // Decoded bytes
  initial rxd = 1'b1;
  // One frame, LSB first, idle gap after stop
  task automatic send(input logic [7:0] b);
    rxd = 1'b0;
    repeat (BIT) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      rxd = b[i];
      repeat (BIT) @(negedge clk);
    end
    rxd = 1'b1;
    repeat (2 * BIT) @(negedge clk);
  endtask : send
  // Short low pulse, too brief for a start bit
  task automatic glitch();
    rxd = 1'b0;
    repeat (4) @(negedge clk);
    rxd = 1'b1;
    repeat (BIT) @(negedge clk);
  endtask : glitch
  // Decoder samples each bit at its centre
  initial begin
    logic [7:0] b;
    forever begin
      @(negedge txd);
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge clk);
        b[i] = txd;
      end
      repeat (BIT) @(posedge clk);
      got.push_back(b);
    end
  end
endmodule : uart_peer
